// ==== design/gpcm_pkg.sv ====
// Constants for the GPIO pin configuration and function multiplexer.
// Assumes a 32-bit Avalon-MM slave with a byte address of ADDR_W bits.
package gpcm_pkg;
	// ==========================================================
	// Geometry
	localparam int NUM_PORTS = 8;
	localparam int PORT_W    = 8;
	localparam int NUM_PINS  = 64;
	localparam int CODE_W    = 4;
	localparam int NUM_CODES = 16;
	localparam int ADDR_W    = 14;
	localparam int PORT_LSB  = 11;
	localparam int MASK_LSB  = 2;

	// ==========================================================
	// Register offsets inside one port window
	localparam logic [10:0] OFF_DIR      = 11'h400;
	localparam logic [10:0] OFF_ISENSE   = 11'h404;
	localparam logic [10:0] OFF_IBOTH    = 11'h408;
	localparam logic [10:0] OFF_IEVENT   = 11'h40c;
	localparam logic [10:0] OFF_IENABLE  = 11'h410;
	localparam logic [10:0] OFF_ISTATUS  = 11'h414;
	localparam logic [10:0] OFF_IMASKED  = 11'h418;
	localparam logic [10:0] OFF_ICLEAR   = 11'h41c;
	localparam logic [10:0] OFF_ALTSEL   = 11'h420;
	localparam logic [10:0] OFF_DRV2     = 11'h500;
	localparam logic [10:0] OFF_DRV4     = 11'h504;
	localparam logic [10:0] OFF_DRV8     = 11'h508;
	localparam logic [10:0] OFF_ODRAIN   = 11'h50c;
	localparam logic [10:0] OFF_PULLUP   = 11'h510;
	localparam logic [10:0] OFF_PULLDN   = 11'h514;
	localparam logic [10:0] OFF_SLEW     = 11'h518;
	localparam logic [10:0] OFF_DIGEN    = 11'h51c;
	localparam logic [10:0] OFF_DRV18    = 11'h520;
	localparam logic [10:0] OFF_PMUX     = 11'h52c;

	// ==========================================================
	// Limits, codes and reset values
	localparam logic [6:0]   DRV18_MAX   = 7'h04;
	localparam logic [3:0]   CODE_SERIAL = 4'h1;
	localparam logic [3:0]   CODE_DEBUG  = 4'h3;
	localparam logic [63:0]  RST_ALTSEL  = 64'h0000_0000_000f_003f;
	localparam logic [63:0]  RST_DIGEN   = 64'h0000_0000_000f_003f;
	localparam logic [63:0]  RST_PULLUP  = 64'h0000_0000_000f_0000;
	localparam logic [63:0]  RST_DRV2    = 64'hffff_ffff_ffff_ffff;
	localparam logic [255:0] RST_PMUX    = {160'h0, 32'h0000_3333, 32'h0, 32'h0011_1111};

	typedef enum logic [0:0] {
		GPCM_BUS_IDLE   = 1'b0,
		GPCM_BUS_ANSWER = 1'b1
	} gpcm_bus_state_t;
endpackage : gpcm_pkg

// ==== design/gpcm_pin_mux.sv ====
// One pin's pad multiplexer: GPIO or a coded peripheral function.
// Assumes the pad input is already synchronised to the core clock.
`timescale 1ns/1ps
module gpcm_pin_mux (
	// Configuration
	input  wire logic        alt_sel_i,
	input  wire logic        dig_en_i,
	input  wire logic        open_drain_i,
	input  wire logic [3:0]  code_i,
	// GPIO side
	input  wire logic        gpio_out_i,
	input  wire logic        gpio_dir_i,
	output logic             dig_in_o,
	// Peripheral side
	input  wire logic [15:0] fn_out_i,
	input  wire logic [15:0] fn_oe_i,
	output logic [15:0]      fn_in_o,
	// Pad
	input  wire logic        pad_sync_i,
	output logic             pad_out_o,
	output logic             pad_oe_n_o
);
	logic fn_path;
	logic drv_val;
	logic drv_en;

	assign fn_path  = alt_sel_i & dig_en_i;
	assign drv_val  = fn_path ? fn_out_i[code_i] : gpio_out_i;
	assign drv_en   = alt_sel_i ? (fn_path & fn_oe_i[code_i]) : gpio_dir_i;
	// Open drain only ever pulls low
	assign pad_out_o  = drv_val;
	assign pad_oe_n_o = ~(drv_en & ~(open_drain_i & drv_val));
	// Cleared digital enable cuts the digital input and the function path, but not the GPIO driver
	assign dig_in_o   = pad_sync_i & dig_en_i;
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			fn_in_o[k] = fn_path && (code_i == 4'(k)) && pad_sync_i;
		end
	end
endmodule : gpcm_pin_mux

// ==== design/gpcm_top.sv ====
// GPIO configuration, interrupt and pad multiplexer block, eight ports of eight pins.
// Assumes an Avalon-MM master on core_clk_i and asynchronous pads.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module gpcm_top (
	// Clock and reset
	input  wire logic                            core_clk_i,
	input  wire logic                            rst_i,
	// Avalon-MM slave
	input  wire logic [gpcm_pkg::ADDR_W-1:0]     avs_address_i,
	input  wire logic                            avs_read_i,
	input  wire logic                            avs_write_i,
	input  wire logic [31:0]                     avs_writedata_i,
	input  wire logic [3:0]                      avs_byteenable_i,
	output logic [31:0]                          avs_readdata_o,
	output logic                                 avs_waitrequest_o,
	// Pads
	input  wire logic [gpcm_pkg::NUM_PINS-1:0]   pad_in_i,
	output logic [gpcm_pkg::NUM_PINS-1:0]        pad_out_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        pad_oe_n_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        pull_up_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        pull_down_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        drive_2ma_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        drive_4ma_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        drive_8ma_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        drive_18ma_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        slew_ctl_o,
	output logic [gpcm_pkg::NUM_PINS-1:0]        analog_en_o,
	// Peripheral functions, sixteen codes per pin
	input  wire logic [gpcm_pkg::NUM_PINS*16-1:0] fn_out_i,
	input  wire logic [gpcm_pkg::NUM_PINS*16-1:0] fn_oe_i,
	output logic [gpcm_pkg::NUM_PINS*16-1:0]      fn_in_o,
	// Interrupt
	output logic                                 irq_o
);
	import gpcm_pkg::*;

	// ==========================================================
	// Configuration state
	logic [63:0]  data_q;
	logic [63:0]  dir_q;
	logic [63:0]  isense_q;
	logic [63:0]  iboth_q;
	logic [63:0]  ievent_q;
	logic [63:0]  ienable_q;
	logic [63:0]  istatus_q;
	logic [63:0]  altsel_q;
	logic [63:0]  digen_q;
	logic [63:0]  pullup_q;
	logic [63:0]  pulldn_q;
	logic [63:0]  odrain_q;
	logic [63:0]  drv2_q;
	logic [63:0]  drv4_q;
	logic [63:0]  drv8_q;
	logic [63:0]  drv18_q;
	logic [63:0]  slew_q;
	logic [255:0] pmux_q;

	// ==========================================================
	// Bus decode
	gpcm_bus_state_t bus_state;
	logic [2:0]      port;
	logic [10:0]     loc;
	logic [7:0]      mask;
	logic [7:0]      wdata8;
	logic [5:0]      sh;
	logic            wr_ok;
	logic            data_wr;
	logic [63:0]     wr_bits;
	logic [63:0]     wr_lane;
	logic [31:0]     rd_value;
	logic [63:0]     gpio_rd;
	logic [63:0]     dig_in;
	logic [63:0]     pad_meta;
	logic [63:0]     pad_sync;
	logic [63:0]     din_d;
	logic [63:0]     evt;
	logic [6:0]      cnt18;
	logic            drv18_ok;

	assign port     = avs_address_i[PORT_LSB +: 3];
	assign loc      = avs_address_i[10:0];
	assign mask     = avs_address_i[MASK_LSB +: 8];
	assign wdata8   = avs_writedata_i[7:0];
	assign sh       = {port, 3'b000};
	assign wr_ok    = avs_write_i && (bus_state == GPCM_BUS_ANSWER) && avs_byteenable_i[0];
	assign data_wr  = wr_ok && !loc[10];
	assign wr_bits  = {56'h0, wdata8} << sh;
	assign wr_lane  = {56'h0, 8'hff} << sh;
	// Two cycles per access keeps a toggle every other cycle
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_state == GPCM_BUS_IDLE);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			bus_state <= GPCM_BUS_IDLE;
		end else begin
			case (bus_state)
				GPCM_BUS_IDLE:   bus_state <= (avs_read_i || avs_write_i) ? GPCM_BUS_ANSWER
				                                                          : GPCM_BUS_IDLE;
				GPCM_BUS_ANSWER: bus_state <= GPCM_BUS_IDLE;
				default:         bus_state <= GPCM_BUS_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Read path
	assign gpio_rd = (dir_q & data_q) | (~dir_q & dig_in);

	always_comb begin
		rd_value = 32'h0;
		if (!loc[10]) begin
			rd_value[7:0] = gpio_rd[sh +: 8] & mask;
		end else begin
			case (loc)
				OFF_DIR:     rd_value[7:0] = dir_q[sh +: 8];
				OFF_ISENSE:  rd_value[7:0] = isense_q[sh +: 8];
				OFF_IBOTH:   rd_value[7:0] = iboth_q[sh +: 8];
				OFF_IEVENT:  rd_value[7:0] = ievent_q[sh +: 8];
				OFF_IENABLE: rd_value[7:0] = ienable_q[sh +: 8];
				OFF_ISTATUS: rd_value[7:0] = istatus_q[sh +: 8];
				OFF_IMASKED: rd_value[7:0] = istatus_q[sh +: 8] & ienable_q[sh +: 8];
				OFF_ALTSEL:  rd_value[7:0] = altsel_q[sh +: 8];
				OFF_DRV2:    rd_value[7:0] = drv2_q[sh +: 8];
				OFF_DRV4:    rd_value[7:0] = drv4_q[sh +: 8];
				OFF_DRV8:    rd_value[7:0] = drv8_q[sh +: 8];
				OFF_ODRAIN:  rd_value[7:0] = odrain_q[sh +: 8];
				OFF_PULLUP:  rd_value[7:0] = pullup_q[sh +: 8];
				OFF_PULLDN:  rd_value[7:0] = pulldn_q[sh +: 8];
				OFF_SLEW:    rd_value[7:0] = slew_q[sh +: 8];
				OFF_DIGEN:   rd_value[7:0] = digen_q[sh +: 8];
				OFF_DRV18:   rd_value[7:0] = drv18_q[sh +: 8];
				OFF_PMUX:    rd_value      = pmux_q[{port, 5'b00000} +: 32];
				default:     rd_value      = 32'h0;
			endcase
		end
	end

	// Captured on the waiting cycle so it stands at the answer edge
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i && bus_state == GPCM_BUS_IDLE) begin
			avs_readdata_o <= rd_value;
		end
	end

	// ==========================================================
	// GPIO data and direction
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			data_q <= 64'h0;
			dir_q  <= 64'h0;
		end else if (wr_ok) begin
			if (!loc[10]) begin
				data_q <= (data_q & ~({56'h0, mask} << sh)) | (wr_bits & ({56'h0, mask} << sh));
			end
			if (loc == OFF_DIR) begin
				dir_q <= (dir_q & ~wr_lane) | wr_bits;
			end
		end
	end

	// ==========================================================
	// Function select and pad controls
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			altsel_q <= RST_ALTSEL;
			digen_q  <= RST_DIGEN;
			pullup_q <= RST_PULLUP;
			pulldn_q <= 64'h0;
			odrain_q <= 64'h0;
			slew_q   <= 64'h0;
		end else if (wr_ok) begin
			case (loc)
				OFF_ALTSEL: altsel_q <= (altsel_q & ~wr_lane) | wr_bits;
				OFF_DIGEN:  digen_q  <= (digen_q & ~wr_lane) | wr_bits;
				OFF_PULLUP: pullup_q <= (pullup_q & ~wr_lane) | wr_bits;
				OFF_PULLDN: pulldn_q <= (pulldn_q & ~wr_lane) | wr_bits;
				OFF_ODRAIN: odrain_q <= (odrain_q & ~wr_lane) | wr_bits;
				OFF_SLEW:   slew_q   <= (slew_q & ~wr_lane) | wr_bits;
				default:    altsel_q <= altsel_q;
			endcase
		end
	end

	// Code bytes follow byte enables so one pair of pins can change alone
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pmux_q <= RST_PMUX;
		end else if (avs_write_i && bus_state == GPCM_BUS_ANSWER && loc == OFF_PMUX) begin
			for (int bl = 0; bl < 4; bl++) begin
				if (avs_byteenable_i[bl]) begin
					pmux_q[{port, 5'b00000} + 8'(bl * 8) +: 8] <= avs_writedata_i[bl * 8 +: 8];
				end
			end
		end
	end

	// ==========================================================
	// Drive strength; a write that would exceed the 18 mA budget is dropped
	always_comb begin
		cnt18 = 7'h0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (3'(i / 8) != port) begin
				cnt18 = cnt18 + 7'(drv18_q[i]);
			end
		end
		for (int b = 0; b < 8; b++) begin
			cnt18 = cnt18 + 7'(wdata8[b]);
		end
		drv18_ok = (cnt18 <= DRV18_MAX);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			drv2_q  <= RST_DRV2;
			drv4_q  <= 64'h0;
			drv8_q  <= 64'h0;
			drv18_q <= 64'h0;
		end else if (wr_ok) begin
			case (loc)
				OFF_DRV2: begin
					drv2_q <= drv2_q | wr_bits;
					drv4_q <= drv4_q & ~wr_bits;
					drv8_q <= drv8_q & ~wr_bits;
				end
				OFF_DRV4: begin
					drv4_q <= drv4_q | wr_bits;
					drv2_q <= drv2_q & ~wr_bits;
					drv8_q <= drv8_q & ~wr_bits;
				end
				OFF_DRV8: begin
					drv8_q <= drv8_q | wr_bits;
					drv2_q <= drv2_q & ~wr_bits;
					drv4_q <= drv4_q & ~wr_bits;
				end
				OFF_DRV18: begin
					if (drv18_ok) begin
						drv18_q <= (drv18_q & ~wr_lane) | wr_bits;
					end
				end
				default: drv2_q <= drv2_q;
			endcase
		end
	end

	assign pull_up_o    = pullup_q;
	assign pull_down_o  = pulldn_q;
	assign drive_2ma_o  = drv2_q;
	assign drive_4ma_o  = drv4_q;
	assign drive_8ma_o  = drv8_q;
	assign drive_18ma_o = drv18_q;
	assign slew_ctl_o   = slew_q & drv8_q;
	assign analog_en_o  = ~digen_q;

	// ==========================================================
	// Interrupt sense and sticky status
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			isense_q  <= 64'h0;
			iboth_q   <= 64'h0;
			ievent_q  <= 64'h0;
			ienable_q <= 64'h0;
		end else if (wr_ok) begin
			case (loc)
				OFF_ISENSE:  isense_q  <= (isense_q & ~wr_lane) | wr_bits;
				OFF_IBOTH:   iboth_q   <= (iboth_q & ~wr_lane) | wr_bits;
				OFF_IEVENT:  ievent_q  <= (ievent_q & ~wr_lane) | wr_bits;
				OFF_IENABLE: ienable_q <= (ienable_q & ~wr_lane) | wr_bits;
				default:     isense_q  <= isense_q;
			endcase
		end
	end

	// A high input at release reads as a rising edge once
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pad_meta  <= 64'h0;
			pad_sync  <= 64'h0;
			din_d     <= 64'h0;
			istatus_q <= 64'h0;
		end else begin
			pad_meta  <= pad_in_i;
			pad_sync  <= pad_meta;
			din_d     <= dig_in;
			// Set wins over a clear in the same cycle
			istatus_q <= (istatus_q & ~((wr_ok && loc == OFF_ICLEAR) ? wr_bits : 64'h0)) | evt;
		end
	end

	assign evt   = (isense_q & ~(ievent_q ^ dig_in))
	             | (~isense_q & iboth_q & (dig_in ^ din_d))
	             | (~isense_q & ~iboth_q & ievent_q & dig_in & ~din_d)
	             | (~isense_q & ~iboth_q & ~ievent_q & ~dig_in & din_d);
	assign irq_o = |(istatus_q & ienable_q);

	// ==========================================================
	// Per-pin multiplexers
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			gpcm_pin_mux u_mux (
				.alt_sel_i    (altsel_q[g]),
				.dig_en_i     (digen_q[g]),
				.open_drain_i (odrain_q[g]),
				.code_i       (pmux_q[g * 4 +: 4]),
				.gpio_out_i   (data_q[g]),
				.gpio_dir_i   (dir_q[g]),
				.dig_in_o     (dig_in[g]),
				.fn_out_i     (fn_out_i[g * 16 +: 16]),
				.fn_oe_i      (fn_oe_i[g * 16 +: 16]),
				.fn_in_o      (fn_in_o[g * 16 +: 16]),
				.pad_sync_i   (pad_sync[g]),
				.pad_out_o    (pad_out_o[g]),
				.pad_oe_n_o   (pad_oe_n_o[g])
			);

			chk_fn_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
				(fn_in_o[g * 16 +: 16] != 16'h0) |-> (altsel_q[g] && digen_q[g]))
				else $error("peripheral input reached without select and enable");
			chk_gpio_owns: assert property (@(posedge core_clk_i) disable iff (rst_i)
				!altsel_q[g] |-> (pad_out_o[g] == data_q[g]) && (pad_oe_n_o[g] ==
				!(dir_q[g] && !(odrain_q[g] && data_q[g]))))
				else $error("gpio does not own pin with select clear");
		end
	endgenerate

	// ==========================================================
	// Checks
	sequence s_write_start;
		avs_write_i && bus_state == GPCM_BUS_IDLE;
	endsequence
	sequence s_rise_seen(int k);
		!isense_q[k] && !iboth_q[k] && ievent_q[k] && dig_in[k] && !din_d[k];
	endsequence

	chk_reset_mux: assert property (@(posedge core_clk_i)
		rst_i |=> (altsel_q == RST_ALTSEL) && (pmux_q == RST_PMUX) && (dir_q == 64'h0))
		else $error("mux controls not at defaults after reset");
	chk_reset_pull: assert property (@(posedge core_clk_i)
		rst_i |=> (pullup_q == RST_PULLUP) && (pulldn_q == 64'h0) && (digen_q == RST_DIGEN))
		else $error("pull or enable not at defaults after reset");
	chk_analog_cut: assert property (@(posedge core_clk_i) disable iff (rst_i)
		((dig_in & ~digen_q) == 64'h0) && (analog_en_o == ~digen_q))
		else $error("digital input active on analog pin");
	chk_edge_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_rise_seen(8) |=> istatus_q[8])
		else $error("rising edge did not set status");
	chk_level_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(isense_q[8] && !ievent_q[8] && !dig_in[8]) [*2] |=> istatus_q[8])
		else $error("low level did not hold status");
	chk_fast_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_write_start |=> !avs_waitrequest_o ##1 (bus_state == GPCM_BUS_IDLE))
		else $error("write not answered within two cycles");
	chk_masked_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		data_wr |=> ((data_q ^ $past(data_q)) & ~$past({56'h0, mask} << sh)) == 64'h0)
		else $error("unmasked data bit changed");
	chk_drv18_limit: assert property (@(posedge core_clk_i) disable iff (rst_i)
		($countones(drv18_q) <= 4) && ((drv2_q & drv4_q) | (drv4_q & drv8_q)) == 64'h0)
		else $error("drive selection out of range");
	chk_irq_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(irq_o) |-> ($past(evt & ienable_q) != 64'h0) || $past(wr_ok && loc == OFF_IENABLE))
		else $error("interrupt rose without an enabled event");
endmodule : gpcm_top

// ==== sim/gpcm_pad_model.sv ====
// Pad partner: the pins outside the block, with outside drivers and pulls.
// Assumes one core clock; a pin nobody drives or pulls flips every cycle.
`timescale 1ns/1ps
module gpcm_pad_model (
	// Clock
	input  wire logic        clk_i,
	// Device pads
	input  wire logic [63:0] pad_out_i,
	input  wire logic [63:0] pad_oe_n_i,
	input  wire logic [63:0] pull_up_i,
	input  wire logic [63:0] pull_down_i,
	// Outside drivers
	input  wire logic [63:0] ext_val_i,
	input  wire logic [63:0] ext_en_i,
	output logic [63:0]      pad_in_o
);
	logic [63:0] flip = 64'h0;

	// ==========
	// Wire level
	always @(posedge clk_i) begin
		flip <= ~flip;
	end
	// A floating pin must not settle to a lucky value
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			if (!pad_oe_n_i[i]) pad_in_o[i] = pad_out_i[i];
			else if (ext_en_i[i]) pad_in_o[i] = ext_val_i[i];
			else if (pull_up_i[i]) pad_in_o[i] = 1'b1;
			else if (pull_down_i[i]) pad_in_o[i] = 1'b0;
			else pad_in_o[i] = flip[i];
		end
	end
endmodule : gpcm_pad_model

// ==== sim/test_gpio_pin_config_mux.sv ====
// Self-checking bench for the pin configuration and function mux.
// Assumes the pad model closes every pin and one bus wait cycle.
`timescale 1ns/1ps
module test_gpio_pin_config_mux;
	import gpcm_pkg::*;
	// ==========
	// Signals
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic [13:0]   addr = 14'h0;
	logic          rd = 1'b0;
	logic          wr = 1'b0;
	logic [31:0]   wdata = 32'h0;
	logic [31:0]   rdata, got, r, m, prev;
	logic          wait_req, irq;
	logic [63:0]   pad_in, pad_out, oe_n, pu, pd, d2, d4, d8, d18, slew, an, snap;
	logic [63:0]   ext_val = 64'h0;
	logic [63:0]   ext_en = 64'h0;
	logic [1023:0] fn_out = 1024'h0;
	logic [1023:0] fn_oe = 1024'h0;
	logic [1023:0] fn_in;
	logic [15:0]   lfsr = 16'hda85;
	logic [5:0]    imode [7] = '{6'h0b, 6'h0c, 6'h05, 6'h15, 6'h13, 6'h2b, 6'h25};
	int            n_mismatch = 0;
	int            total_checks = 0;

	always #20 clk = ~clk;

	gpcm_top gpcm_top_inst (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(oe_n), .pull_up_o(pu),
		.pull_down_o(pd), .drive_2ma_o(d2), .drive_4ma_o(d4), .drive_8ma_o(d8),
		.drive_18ma_o(d18), .slew_ctl_o(slew), .analog_en_o(an), .fn_out_i(fn_out),
		.fn_oe_i(fn_oe), .fn_in_o(fn_in), .irq_o(irq));
	gpcm_pad_model gpcm_pad_model_inst (.clk_i(clk), .pad_out_i(pad_out), .pad_oe_n_i(oe_n),
		.pull_up_i(pu), .pull_down_i(pd), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pad_in_o(pad_in));

	// ==========
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [31:0] def_en(input int p);
		return (p == 0) ? 32'h3f : ((p == 2) ? 32'h0f : 32'h0);
	endfunction : def_en
	function automatic logic [31:0] def_mux(input int p);
		return (p == 0) ? 32'h0011_1111 : ((p == 2) ? 32'h3333 : 32'h0);
	endfunction : def_mux
	task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] act);
		total_checks++;
		if (act !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, act);
		end
	endtask : check_val
	task automatic check_pin(input string what, input logic exp, input logic act);
		total_checks++;
		if (act !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", what, exp, act);
		end
	endtask : check_pin
	// Request stays up between calls so back-to-back accesses have no gap
	task automatic bus(input logic w, input int p, input logic [10:0] o, input logic [31:0] d);
		int n;
		n = 0;
		addr <= {p[2:0], o};
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (n >= 20) n_mismatch++;
		got = rdata;
		snap = pad_out;
	endtask : bus
	task automatic idle(input int c);
		rd <= 1'b0;
		wr <= 1'b0;
		repeat (c) @(posedge clk);
	endtask : idle
	task automatic rd_chk(input string what, input int p, input logic [10:0] o, input logic [31:0] e);
		bus(1'b0, p, o, 32'h0);
		check_val(what, {32'h0, e}, {32'h0, got});
	endtask : rd_chk
	task automatic check_defaults();
		for (int p = 0; p < 8; p++) begin
			rd_chk("altsel", p, OFF_ALTSEL, def_en(p));
			rd_chk("digen", p, OFF_DIGEN, def_en(p));
			rd_chk("pullup", p, OFF_PULLUP, (p == 2) ? 32'h0f : 32'h0);
			rd_chk("pulldn", p, OFF_PULLDN, 32'h0);
			rd_chk("pmux", p, OFF_PMUX, def_mux(p));
			rd_chk("dir", p, OFF_DIR, 32'h0);
			rd_chk("drv18", p, OFF_DRV18, 32'h0);
		end
		idle(1);
		check_val("pullup pins", 64'h000f_0000, pu);
		check_val("tristate", {64{1'b1}}, oe_n);
		check_val("analog", ~64'h000f_003f, an);
		check_pin("irq", 1'b0, irq);
	endtask : check_defaults
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict

	// ==========
	// Scenarios
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_defaults();
		fn_oe[1] <= 1'b1;
		fn_out[1] <= 1'b1;
		fn_oe[18] <= 1'b1;
		ext_en[2] <= 1'b1;
		ext_val[2] <= 1'b1;
		idle(4);
		check_pin("a0 drive", 1'b0, oe_n[0]);
		check_pin("a0 value", 1'b1, pad_out[0]);
		check_pin("a1 other code", 1'b1, oe_n[1]);
		check_pin("a2 input", 1'b1, fn_in[33]);
		bus(1'b1, 0, OFF_PMUX, 32'h0011_1121);
		idle(4);
		check_pin("a1 code 2", 1'b0, oe_n[1]);
		check_pin("a0 kept", 1'b0, oe_n[0]);
		bus(1'b1, 0, OFF_DIGEN, 32'h3a);
		idle(4);
		check_pin("a0 no enable", 1'b1, oe_n[0]);
		check_pin("a2 analog", 1'b1, an[2]);
		check_pin("a2 cut", 1'b0, fn_in[33]);
		bus(1'b1, 0, OFF_ALTSEL, 32'h0);
		bus(1'b1, 0, OFF_DIR, 32'h02);
		bus(1'b1, 0, 11'h008, 32'h02);
		idle(4);
		check_pin("a1 gpio", 1'b0, oe_n[1]);
		check_pin("a1 gpio value", 1'b1, pad_out[1]);
		bus(1'b1, 4, OFF_DIR, 32'hff);
		bus(1'b1, 4, 11'h3fc, 32'h0);
		prev = 32'h0;
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			r = {24'h0, lfsr[7:4], ~prev[3], lfsr[2:0]};
			bus(1'b1, 4, 11'h020, r);
			check_pin("toggle", prev[3], snap[35]);
			prev = r;
		end
		lfsr = lfsr_next(lfsr);
		r = {24'h0, lfsr[7:0]};
		m = {24'h0, lfsr[15:8]};
		bus(1'b1, 4, 11'h3fc, r);
		bus(1'b1, 4, {1'b0, m[7:0], 2'b00}, ~r);
		idle(4);
		rd_chk("masked write", 4, 11'h3fc, r ^ m);
		rd_chk("masked read", 4, {1'b0, m[7:0], 2'b00}, (r ^ m) & m);
		bus(1'b1, 5, OFF_DRV4, 32'h02);
		bus(1'b1, 5, OFF_DRV8, 32'h01);
		bus(1'b1, 5, OFF_SLEW, 32'h03);
		bus(1'b1, 5, OFF_PULLDN, 32'h80);
		bus(1'b1, 5, OFF_DRV18, 32'h1f);
		rd_chk("18ma over", 5, OFF_DRV18, 32'h0);
		bus(1'b1, 5, OFF_DRV18, 32'h0f);
		bus(1'b1, 6, OFF_DRV18, 32'h01);
		rd_chk("18ma fifth", 6, OFF_DRV18, 32'h0);
		bus(1'b1, 5, OFF_DIR, 32'h04);
		bus(1'b1, 5, OFF_ODRAIN, 32'h04);
		bus(1'b1, 5, 11'h010, 32'h04);
		idle(1);
		check_pin("odrain high", 1'b1, oe_n[42]);
		check_val("drive 8", 64'h1 << 40, d8);
		check_val("drive 2", ~(64'h3 << 40), d2);
		check_val("drive 4", 64'h2 << 40, d4);
		check_val("slew", 64'h1 << 40, slew);
		check_val("18ma", 64'hf << 40, d18);
		check_val("pulldn", 64'h80 << 40, pd);
		bus(1'b1, 5, 11'h010, 32'h0);
		idle(1);
		check_pin("odrain low", 1'b0, oe_n[42]);
		bus(1'b1, 1, OFF_DIGEN, 32'h01);
		ext_en[8] <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			ext_val[8] <= imode[k][2];
			bus(1'b1, 1, OFF_ISENSE, {31'h0, imode[k][5]});
			bus(1'b1, 1, OFF_IBOTH, {31'h0, imode[k][4]});
			bus(1'b1, 1, OFF_IEVENT, {31'h0, imode[k][3]});
			idle(5);
			bus(1'b1, 1, OFF_ICLEAR, 32'h01);
			bus(1'b1, 1, OFF_IENABLE, 32'h01);
			idle(1);
			check_pin("irq quiet", 1'b0, irq);
			ext_val[8] <= imode[k][1];
			idle(5);
			check_pin("irq raised", imode[k][0], irq);
			bus(1'b0, 1, OFF_ISTATUS, 32'h0);
			check_pin("status", imode[k][0], got[0]);
			rd_chk("masked status", 1, OFF_IMASKED, {31'h0, imode[k][0]});
			bus(1'b1, 1, OFF_IENABLE, 32'h0);
			idle(1);
			check_pin("irq masked", 1'b0, irq);
			bus(1'b1, 1, OFF_ICLEAR, 32'h01);
			bus(1'b0, 1, OFF_ISTATUS, 32'h0);
			check_pin("cleared", imode[k][5] & imode[k][0], got[0]);
		end
		lfsr = lfsr_next(lfsr);
		r = {lfsr, lfsr_next(lfsr)};
		bus(1'b1, 3, OFF_PMUX, r);
		rd_chk("pmux any", 3, OFF_PMUX, r);
		bus(1'b1, 1, 11'h600, 32'hff);
		rd_chk("unmapped", 1, 11'h600, 32'h0);
		fn_oe <= 1024'h0;
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		@(posedge clk);
		check_defaults();
		print_verdict();
	end

	initial begin
		#(40 * 4000);
		n_mismatch++;
		print_verdict();
	end
endmodule : test_gpio_pin_config_mux
